/* sdi12_sensor_responder_bench.sv */
// Bench: recorder model on the wire, reply body fed from here
`timescale 1ns/100ps
module sdi12_sensor_responder_bench
    import sdr_pkg::*;
;
    localparam int BITC = 16;
    logic       ref_clk = 1'b0, rst_b = 1'b0, addr_we = 1'b0;
    logic       rsp_last = 1'b0, rsp_valid = 1'b0;
    logic [6:0] addr = 7'h00, rsp_data = 7'h00, addr_cur;
    logic       line_o, line_oe_b, rec_drv, rec_val, rsp_ready, cmd_valid, cmd_crc, awake;
    logic [3:0] cmd_idx;
    sdr_cmd_t   cmd_code;
    wire        line;
    int         n_mismatch = 0, cmp_count = 0, n_hit = 0;
    always #4 ref_clk = ~ref_clk;
    // Pull-down keeps a released wire at mark
    assign line = !line_oe_b ? line_o : (rec_drv ? rec_val : 1'b0);
    // Count command pulses; each lasts one cycle
    always @(posedge ref_clk) if (cmd_valid === 1'b1) n_hit <= n_hit + 1;
    sdr_responder #(.BIT_CYC_P(24'h10), .ACTIVE_CYC_P(24'h190), .TURN_CYC_P(24'h14)) i_dut (
        .ref_clk_i(ref_clk), .rst_b_i(rst_b), .line_i(line), .line_o(line_o),
        .line_oe_b_o(line_oe_b), .addr_i(addr), .addr_we_i(addr_we), .addr_o(addr_cur),
        .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_crc_o(cmd_crc),
        .cmd_idx_o(cmd_idx), .rsp_data_i(rsp_data), .rsp_last_i(rsp_last),
        .rsp_valid_i(rsp_valid), .rsp_ready_o(rsp_ready), .awake_o(awake));
    sdr_recorder #(.BITC(BITC)) i_rec (
        .ref_clk_i(ref_clk), .line_i(line), .drv_o(rec_drv), .val_o(rec_val));
    task automatic test_done();
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    // Held until ready is sampled high at an edge
    task automatic push(input logic [6:0] c, input logic last);
        @(posedge ref_clk);
        #1 {rsp_valid, rsp_data, rsp_last} = {1'b1, c, last};
        do @(posedge ref_clk); while (rsp_ready !== 1'b1);
        #1 rsp_valid = 1'b0;
    endtask : push
    task automatic cmd(input string s);
        for (int i = 0; i < s.len(); i++) i_rec.send(7'(s.getc(i)));
    endtask : cmd
    task automatic reply(input string s);
        logic [6:0] c;
        logic       ok;
        for (int i = 0; i < s.len(); i++) begin
            i_rec.get(c, ok);
            chk(ok && c === 7'(s.getc(i)), "reply char");
        end
        // Let the sensor finish its stop bit and release before the next command
        repeat (BITC) @(posedge ref_clk);
    endtask : reply
    task automatic t_other();
        int k, h;
        h = n_hit;
        cmd("1M!");
        chk(awake === 1'b1, "no wake");
        for (k = 0; k < 600 && awake === 1'b1; k++) begin
            @(posedge ref_clk);
            chk(line_oe_b === 1'b1 && n_hit == h, "foreign reply");
        end
        chk(k > 350 && k < 460, "sleep time");
    endtask : t_other
    // Fill the reply buffer until it refuses, then drain it in one reply
    task automatic t_fill();
        int h;
        h = n_hit;
        for (int i = 0; i < 8; i++) push(7'h41 + 7'(i), i == 7);
        @(posedge ref_clk);
        #1;
        chk(rsp_ready === 1'b0, "buffer not full");
        cmd("0M1!");
        reply("0ABCDEFGH\015\012");
        chk(n_hit == h + 1 && cmd_code === CMD_M && cmd_idx === 4'h1, "decode");
        repeat (BITC) @(posedge ref_clk);
        chk(line_oe_b === 1'b1 && line === 1'b0 && rsp_ready === 1'b1, "release");
    endtask : t_fill
    task automatic t_addr();
        int h;
        @(posedge ref_clk);
        #1 {addr, addr_we} = {7'h35, 1'b1};
        @(posedge ref_clk);
        #1 addr_we = 1'b0;
        @(posedge ref_clk);
        chk(addr_cur === 7'h35, "address load");
        h = n_hit;
        cmd("0V!");
        repeat (60) @(posedge ref_clk);
        chk(n_hit == h && line_oe_b === 1'b1, "old address answered");
        cmd("?!");
        reply("5\015\012");
        // Bare acknowledge: address, CR, LF and no command pulse
        cmd("5!");
        reply("5\015\012");
        chk(n_hit == h, "query or acknowledge pulsed");
    endtask : t_addr
    // Every pulsed command family: M, C and R with and without the CRC variant, then V and I
    task automatic t_codes();
        string    s [8] = '{"5M!", "5MC!", "5C!", "5CC2!", "5R3!", "5RC0!", "5V!", "5I!"};
        sdr_cmd_t e [8] = '{CMD_M, CMD_M, CMD_C, CMD_C, CMD_R, CMD_R, CMD_V, CMD_I};
        int       h;
        for (int i = 0; i < 8; i++) begin
            h = n_hit;
            push(7'h78, 1'b1);
            cmd(s[i]);
            reply("5x\015\012");
            chk(n_hit == h + 1 && cmd_code === e[i], "code");
            chk(cmd_crc === (s[i].getc(2) == 8'h43), "crc flag");
        end
    endtask : t_codes
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(addr_cur === 7'h30 && awake === 1'b0 && line_oe_b === 1'b1, "reset");
        t_other();
        t_fill();
        t_addr();
        t_codes();
        test_done();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_mismatch++;
        test_done();
    end
endmodule : sdi12_sensor_responder_bench

/* sdr_fifo.sv */
// Reply character FIFO with registered ready and valid flags
`timescale 1ns/100ps
module sdr_fifo
    import sdr_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic  ref_clk_i,
    input wire logic  rst_b_i,
    // Both sides
    sdr_fifo_if.store io
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          rdy_q, rdy_d, vld_q, vld_d, push, pop;
    logic [W-1:0]  ent_q [DEPTH];
    logic [W-1:0]  ent_d [DEPTH];

    // Pointer and level update; flags are registered so ports come from flops
    always_comb begin
        push  = io.wvalid && rdy_q;
        pop   = io.rready && vld_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        if (push) wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        if (pop) rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        cnt_d = cnt_q + CW'(push) - CW'(pop);
        rdy_d = cnt_d != CW'(DEPTH);
        vld_d = cnt_d != '0;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
            vld_q <= 1'b0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            vld_q <= vld_d;
        end
    end

    // One storage word per entry
    for (genvar g = 0; g < DEPTH; g++) begin : g_ent
        assign ent_d[g] = (push && wr_q == AW'(g)) ? io.wdata : ent_q[g];
        always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) ent_q[g] <= '0;
            else ent_q[g] <= ent_d[g];
        end
    end

    assign io.rdata  = ent_q[rd_q];
    assign io.wready = rdy_q;
    assign io.rvalid = vld_q;
endmodule : sdr_fifo

/* sdr_fifo_if.sv */
// Valid/ready carrier between the responder and its reply FIFO
`timescale 1ns/100ps
interface sdr_fifo_if #(parameter int W = 8);
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic         wvalid;
    logic         wready;
    logic         rvalid;
    logic         rready;
    modport store (input wdata, wvalid, rready, output wready, rdata, rvalid);
    modport user  (output wdata, wvalid, rready, input wready, rdata, rvalid);
endinterface : sdr_fifo_if

/* sdr_pkg.sv */
// Shared constants and types for the SDI-12 sensor responder
package sdr_pkg;
    // Clock and link timing
    localparam int unsigned CLK_HZ     = 125_000_000;
    localparam int unsigned BAUD       = 1200;
    localparam int unsigned BIT_CYC    = CLK_HZ / BAUD;
    localparam int unsigned ACTIVE_MS  = 100;
    localparam int unsigned ACTIVE_CYC = CLK_HZ / 1000 * ACTIVE_MS;
    localparam int unsigned TURN_US    = 1000;
    localparam int unsigned TURN_CYC   = CLK_HZ / 1_000_000 * TURN_US;
    localparam int unsigned CNT_W      = 24;
    // Character framing: start, 7 data, even parity, stop
    localparam int unsigned CHAR_BITS  = 10;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned CMD_MAX    = 3;
    // Characters
    localparam logic [6:0] CH_BANG  = 7'h21;
    localparam logic [6:0] CH_QUERY = 7'h3f;
    localparam logic [6:0] CH_CR    = 7'h0d;
    localparam logic [6:0] CH_LF    = 7'h0a;
    localparam logic [6:0] CH_M     = 7'h4d;
    localparam logic [6:0] CH_C     = 7'h43;
    localparam logic [6:0] CH_R     = 7'h52;
    localparam logic [6:0] CH_V     = 7'h56;
    localparam logic [6:0] CH_I     = 7'h49;
    localparam logic [6:0] CH_0     = 7'h30;
    localparam logic [6:0] CH_9     = 7'h39;
    // Address after reset
    localparam logic [6:0] ADDR_RST = 7'h30;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_ACK, CMD_QUERY, CMD_M, CMD_C, CMD_R, CMD_V, CMD_I
    } sdr_cmd_t;
    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00, ST_LISTEN = 2'b01, ST_TURN = 2'b11, ST_SEND = 2'b10
    } sdr_state_t;
    typedef enum logic [1:0] {
        PH_ADDR = 2'b00, PH_BODY = 2'b01, PH_CR = 2'b11, PH_LF = 2'b10
    } sdr_phase_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b11
    } sdr_rx_t;
endpackage : sdr_pkg

/* sdr_recorder.sv */
// Recorder model on the shared wire: sends commands, reads replies
`timescale 1ns/100ps
module sdr_recorder #(
    parameter int BITC = 16
) (
    input  wire logic ref_clk_i,
    input  wire logic line_i,
    output logic      drv_o,
    output logic      val_o
);
    // Released at time zero so the pull-down holds mark
    initial {drv_o, val_o} = 2'b00;
    // One 7E1 frame: start high, data inverted, then the wire is let go
    task automatic send(input logic [6:0] c);
        logic [9:0] f;
        f = {1'b0, ~(^c), ~c, 1'b1};
        @(posedge ref_clk_i);
        #1 drv_o = 1'b1;
        for (int i = 0; i < 10; i++) begin
            val_o = f[i];
            repeat (BITC) @(posedge ref_clk_i);
            #1;
        end
        {drv_o, val_o} = 2'b00;
    endtask : send
    // Mid-bit sampling tolerates the sender's latency
    task automatic get(output logic [6:0] c, output logic ok);
        logic [7:0] b;
        int         k;
        k = 0;
        while (line_i !== 1'b1 && k < 4000) begin
            @(posedge ref_clk_i);
            k++;
        end
        repeat (BITC / 2) @(posedge ref_clk_i);
        ok = (line_i === 1'b1);
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge ref_clk_i);
            b[i] = ~line_i;
        end
        c = b[6:0];
        repeat (BITC) @(posedge ref_clk_i);
        ok = ok && (^b === 1'b0) && (line_i === 1'b0);
    endtask : get
endmodule : sdr_recorder

/* sdr_responder.sv */
// SDI-12 sensor end: line receiver, command decode, wake timing, reply sender
// Operation
// [R1] M, MC, C, CC, R, RC, V, address query and I commands are recognised and answered.
// [R2] The port holds one address and commands carrying another address are ignored.
// [R3] Each port instance keeps its own address register, set independently.
// [R4] Any start bit on the wire wakes the block from sleep, whatever the address.
// [R5] Only an addressed block drives the wire; all others leave it released.
// [R6] An awake block returns to sleep only when its inactivity counter runs out.
// [R7] A command is one address character, body, then '!'; '?' is the query wildcard.
// [R8] Every reply ends with carriage return then line feed.
// [R9] Characters are sent and sampled at 1200 baud.
// [R10] After the last reply character the wire is released to idle.
`timescale 1ns/100ps
module sdr_responder
    import sdr_pkg::*;
#(
    parameter logic [CNT_W-1:0] BIT_CYC_P    = CNT_W'(BIT_CYC),
    parameter logic [CNT_W-1:0] ACTIVE_CYC_P = CNT_W'(ACTIVE_CYC),
    parameter logic [CNT_W-1:0] TURN_CYC_P   = CNT_W'(TURN_CYC)
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_b_i,
    // Shared SDI-12 wire (high level is a space)
    input  wire logic       line_i,
    output logic            line_o,
    output logic            line_oe_b_o,
    // Address setting
    input  wire logic [6:0] addr_i,
    input  wire logic       addr_we_i,
    output logic      [6:0] addr_o,
    // Decoded commands
    output logic            cmd_valid_o,
    output sdr_cmd_t        cmd_code_o,
    output logic            cmd_crc_o,
    output logic      [3:0] cmd_idx_o,
    // Reply body characters
    input  wire logic [6:0] rsp_data_i,
    input  wire logic       rsp_last_i,
    input  wire logic       rsp_valid_i,
    output logic            rsp_ready_o,
    // Status
    output logic            awake_o
);
    logic             rst_s1_q, rst_s2_q;
    logic             ln_s1_q, ln_s2_q, ln_s3_q, ln_q, ln_d, mark, rx_en, wake;
    sdr_rx_t          rx_st_q, rx_st_d;
    logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d;
    logic [3:0]       rx_bit_q, rx_bit_d;
    logic [8:0]       rx_sh_q, rx_sh_d;
    logic             rx_vld_q, rx_vld_d;
    logic [6:0]       rx_chr_q, rx_chr_d;
    logic             got_q, got_d, ovf_q, ovf_d, hit, dec_crc;
    logic [6:0]       adr_q, adr_d;
    logic [1:0]       len_q, len_d;
    logic [6:0]       body_q [CMD_MAX];
    logic [6:0]       body_d [CMD_MAX];
    sdr_cmd_t         dec_k;
    logic [3:0]       dec_idx;
    sdr_state_t       st_q, st_d;
    sdr_phase_t       ph_q, ph_d;
    logic [CNT_W-1:0] tmr_q, tmr_d, tx_cnt_q, tx_cnt_d;
    logic             fin_q, fin_d, nobody_q, nobody_d, tx_busy_q, tx_busy_d;
    logic [9:0]       tx_sh_q, tx_sh_d;
    logic [3:0]       tx_bit_q, tx_bit_d;
    logic             tx_load, pop;
    logic [6:0]       tx_chr, addr_q, addr_d, last_chr_q;
    logic             line_q, line_d, oe_b_q, oe_b_d, awake_q, awake_d;
    logic             cmdv_q, cmdv_d, crc_q, crc_d;
    sdr_cmd_t         code_q, code_d;
    logic [3:0]       idx_q, idx_d;
    // Reply body FIFO carrier, declared early because the sender reads it
    sdr_fifo_if #(.W(8)) ff ();

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // Wire input: three flops, a level counts once the last two agree
    assign ln_d  = (ln_s2_q == ln_s3_q) ? ln_s2_q : ln_q;
    assign mark  = !ln_q;
    assign rx_en = st_q == ST_SLEEP || st_q == ST_LISTEN;
    assign wake  = rx_en && rx_st_q == RX_IDLE && !mark;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ln_s1_q <= 1'b0;
            ln_s2_q <= 1'b0;
            ln_s3_q <= 1'b0;
            ln_q    <= 1'b0;
        end else begin
            ln_s1_q <= line_i;
            ln_s2_q <= ln_s1_q;
            ln_s3_q <= ln_s2_q;
            ln_q    <= ln_d;
        end
    end

    // Receiver: start bit checked at mid-bit, then nine samples one bit apart
    always_comb begin
        rx_st_d  = rx_st_q;
        rx_cnt_d = rx_cnt_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d  = rx_sh_q;
        rx_vld_d = 1'b0;
        rx_chr_d = rx_chr_q;
        if (!rx_en) begin
            rx_st_d = RX_IDLE; // Own reply would echo back, so listening pauses
        end else begin
            case (rx_st_q)
                RX_IDLE: if (!mark) begin
                    rx_st_d  = RX_START;
                    rx_cnt_d = BIT_CYC_P >> 1;
                end
                RX_START: if (rx_cnt_q != '0) begin
                    rx_cnt_d = rx_cnt_q - 1'b1;
                end else if (!mark) begin
                    rx_st_d  = RX_BITS;
                    rx_cnt_d = BIT_CYC_P - 1'b1; // see [R9]
                    rx_bit_d = 4'h0;
                end else begin
                    rx_st_d = RX_IDLE; // Glitch, not a start bit
                end
                RX_BITS: if (rx_cnt_q != '0) begin
                    rx_cnt_d = rx_cnt_q - 1'b1;
                end else begin
                    rx_sh_d  = {mark, rx_sh_q[8:1]};
                    rx_cnt_d = BIT_CYC_P - 1'b1; // see [R9]
                    rx_bit_d = rx_bit_q + 1'b1;
                    if (rx_bit_q == 4'(CHAR_BITS - 2)) begin
                        rx_st_d  = RX_IDLE;
                        // Stop bit must be a mark and parity even
                        rx_vld_d = rx_sh_d[8] && !(^rx_sh_d[7:0]);
                        rx_chr_d = rx_sh_d[6:0];
                    end
                end
                default: rx_st_d = RX_IDLE;
            endcase
        end
    end

    // Command decode from the collected address and body characters
    always_comb begin
        logic       hasc;
        logic [6:0] dch;
        logic       dig;
        logic [1:0] n;
        hasc    = len_q[1] && body_q[1] == CH_C;
        dch     = hasc ? body_q[2] : body_q[1];
        dig     = dch >= CH_0 && dch <= CH_9;
        n       = hasc ? 2'd2 : 2'd1;
        dec_k   = CMD_NONE;
        dec_idx = 4'h0;
        if (ovf_q || !got_q) begin
            dec_k = CMD_NONE;
        end else if (len_q == 2'd0) begin
            dec_k = (adr_q == CH_QUERY) ? CMD_QUERY : CMD_ACK; // see [R7]
        end else if (len_q == 2'd1 && body_q[0] == CH_V) begin
            dec_k = CMD_V;
        end else if (len_q == 2'd1 && body_q[0] == CH_I) begin
            dec_k = CMD_I;
        end else if (len_q == n + 2'd1 && dig) begin
            dec_idx = 4'(dch - CH_0);
            dec_k   = body_q[0] == CH_M ? CMD_M : body_q[0] == CH_C ? CMD_C :
                      body_q[0] == CH_R ? CMD_R : CMD_NONE; // see [R1]
        end else if (len_q == n) begin
            // R always needs its digit
            dec_k = body_q[0] == CH_M ? CMD_M : body_q[0] == CH_C ? CMD_C : CMD_NONE;
        end
        dec_crc = hasc && (dec_k == CMD_M || dec_k == CMD_C || dec_k == CMD_R);
    end

    // Matching terminator: our address, or the wildcard on a bare query
    assign hit = st_q == ST_LISTEN && rx_vld_q && rx_chr_q == CH_BANG &&
                 dec_k != CMD_NONE &&
                 (dec_k == CMD_QUERY || adr_q == addr_q); // see [R2] see [R5]

    // Parser registers and command outputs
    always_comb begin
        got_d  = got_q;
        adr_d  = adr_q;
        len_d  = len_q;
        ovf_d  = ovf_q;
        body_d = body_q;
        addr_d = addr_we_i ? addr_i : addr_q; // see [R3]
        cmdv_d = hit && dec_k != CMD_ACK && dec_k != CMD_QUERY;
        code_d = hit ? dec_k : code_q;
        crc_d  = hit ? dec_crc : crc_q;
        idx_d  = hit ? dec_idx : idx_q;
        if (st_q == ST_SLEEP || (rx_vld_q && rx_chr_q == CH_BANG)) begin
            got_d = 1'b0; // see [R7]
            len_d = 2'd0;
            ovf_d = 1'b0;
        end else if (rx_vld_q && !got_q) begin
            got_d = 1'b1;
            adr_d = rx_chr_q;
        end else if (rx_vld_q && len_q == 2'(CMD_MAX)) begin
            ovf_d = 1'b1; // Too long for any supported command
        end else if (rx_vld_q) begin
            body_d[len_q] = rx_chr_q;
            len_d         = len_q + 1'b1;
        end
    end

    // Link control and bit sender
    always_comb begin
        st_d      = st_q;
        ph_d      = ph_q;
        tmr_d     = tmr_q;
        fin_d     = fin_q;
        nobody_d  = nobody_q;
        tx_sh_d   = tx_sh_q;
        tx_cnt_d  = tx_cnt_q;
        tx_bit_d  = tx_bit_q;
        tx_busy_d = tx_busy_q;
        tx_load   = 1'b0;
        tx_chr    = CH_CR;
        pop       = 1'b0;
        if (tx_busy_q) begin
            if (tx_cnt_q != '0) begin
                tx_cnt_d = tx_cnt_q - 1'b1;
            end else begin
                tx_sh_d   = {1'b1, tx_sh_q[9:1]};
                tx_cnt_d  = BIT_CYC_P - 1'b1; // see [R9]
                tx_bit_d  = tx_bit_q + 1'b1;
                tx_busy_d = tx_bit_q != 4'(CHAR_BITS - 1);
            end
        end
        case (st_q)
            ST_SLEEP: if (wake) begin
                st_d  = ST_LISTEN; // see [R4]
                tmr_d = ACTIVE_CYC_P;
            end
            ST_LISTEN: if (hit) begin
                st_d     = ST_TURN;
                tmr_d    = TURN_CYC_P;
                nobody_d = dec_k == CMD_ACK || dec_k == CMD_QUERY;
            end else if (rx_st_q != RX_IDLE || rx_vld_q) begin
                tmr_d = ACTIVE_CYC_P; // Traffic for anyone keeps us awake
            end else if (tmr_q == '0) begin
                st_d = ST_SLEEP; // see [R6]
            end else begin
                tmr_d = tmr_q - 1'b1;
            end
            ST_TURN: if (tmr_q == '0) begin
                st_d  = ST_SEND;
                ph_d  = PH_ADDR;
                fin_d = 1'b0;
            end else begin
                tmr_d = tmr_q - 1'b1;
            end
            default: if (!tx_busy_q) begin
                if (fin_q) begin
                    st_d  = ST_LISTEN; // see [R10]
                    tmr_d = ACTIVE_CYC_P;
                end else begin
                    case (ph_q)
                        PH_ADDR: begin
                            tx_load = 1'b1;
                            tx_chr  = addr_q;
                            ph_d    = nobody_q ? PH_CR : PH_BODY;
                        end
                        PH_BODY: if (ff.rvalid) begin
                            // A slow reply source stalls here, holding mark
                            tx_load = 1'b1;
                            tx_chr  = ff.rdata[6:0];
                            pop     = 1'b1;
                            if (ff.rdata[7]) ph_d = PH_CR;
                        end
                        PH_CR: begin
                            tx_load = 1'b1; // see [R8]
                            tx_chr  = CH_CR;
                            ph_d    = PH_LF;
                        end
                        default: begin
                            tx_load = 1'b1; // see [R8]
                            tx_chr  = CH_LF;
                            fin_d   = 1'b1;
                        end
                    endcase
                end
            end
        endcase
        if (tx_load) begin
            tx_sh_d   = {1'b1, ^tx_chr, tx_chr, 1'b0};
            tx_cnt_d  = BIT_CYC_P - 1'b1;
            tx_bit_d  = 4'h0;
            tx_busy_d = 1'b1;
        end
    end

    // Drive only while replying; space is a high level on the wire
    assign line_d  = tx_busy_d && !tx_sh_d[0];
    assign oe_b_d  = st_d != ST_SEND; // see [R5] see [R10]
    assign awake_d = st_d != ST_SLEEP;

    always_ff @(posedge ref_clk_i or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            rx_st_q    <= RX_IDLE;
            rx_cnt_q   <= '0;
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= 9'h000;
            rx_vld_q   <= 1'b0;
            rx_chr_q   <= 7'h00;
            got_q      <= 1'b0;
            adr_q      <= 7'h00;
            len_q      <= 2'd0;
            ovf_q      <= 1'b0;
            body_q     <= '{default: 7'h00};
            addr_q     <= ADDR_RST;
            cmdv_q     <= 1'b0;
            code_q     <= CMD_NONE;
            crc_q      <= 1'b0;
            idx_q      <= 4'h0;
            st_q       <= ST_SLEEP;
            ph_q       <= PH_ADDR;
            tmr_q      <= '0;
            fin_q      <= 1'b0;
            nobody_q   <= 1'b0;
            tx_sh_q    <= 10'h3ff;
            tx_cnt_q   <= '0;
            tx_bit_q   <= 4'h0;
            tx_busy_q  <= 1'b0;
            line_q     <= 1'b0;
            oe_b_q     <= 1'b1;
            awake_q    <= 1'b0;
            last_chr_q <= 7'h00;
        end else begin
            rx_st_q    <= rx_st_d;
            rx_cnt_q   <= rx_cnt_d;
            rx_bit_q   <= rx_bit_d;
            rx_sh_q    <= rx_sh_d;
            rx_vld_q   <= rx_vld_d;
            rx_chr_q   <= rx_chr_d;
            got_q      <= got_d;
            adr_q      <= adr_d;
            len_q      <= len_d;
            ovf_q      <= ovf_d;
            body_q     <= body_d;
            addr_q     <= addr_d;
            cmdv_q     <= cmdv_d;
            code_q     <= code_d;
            crc_q      <= crc_d;
            idx_q      <= idx_d;
            st_q       <= st_d;
            ph_q       <= ph_d;
            tmr_q      <= tmr_d;
            fin_q      <= fin_d;
            nobody_q   <= nobody_d;
            tx_sh_q    <= tx_sh_d;
            tx_cnt_q   <= tx_cnt_d;
            tx_bit_q   <= tx_bit_d;
            tx_busy_q  <= tx_busy_d;
            line_q     <= line_d;
            oe_b_q     <= oe_b_d;
            awake_q    <= awake_d;
            last_chr_q <= tx_load ? tx_chr : last_chr_q;
        end
    end

    // Reply body FIFO
    assign ff.wdata  = {rsp_last_i, rsp_data_i};
    assign ff.wvalid = rsp_valid_i;
    assign ff.rready = pop;

    sdr_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_s2_q),
        .io        (ff)
    );

    assign line_o      = line_q;
    assign line_oe_b_o = oe_b_q;
    assign addr_o      = addr_q;
    assign cmd_valid_o = cmdv_q;
    assign cmd_code_o  = code_q;
    assign cmd_crc_o   = crc_q;
    assign cmd_idx_o   = idx_q;
    assign rsp_ready_o = ff.wready;
    assign awake_o     = awake_q;

    // Checks on the link behaviour
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_s2_q);
    sequence reply_end_s;
        st_q == ST_SEND ##1 st_q == ST_LISTEN;
    endsequence
    sequence foreign_cmd_s;
        st_q == ST_LISTEN && rx_vld_q && rx_chr_q == CH_BANG &&
        adr_q != addr_q && adr_q != CH_QUERY;
    endsequence

    fam_only_a: assert property (cmd_valid_o |-> code_q inside {CMD_M, CMD_C, CMD_R, CMD_V, CMD_I}) // see [R1]
        else $error("command pulse with unsupported code");
    foreign_cmd_a: assert property (foreign_cmd_s |=> st_q != ST_TURN) // see [R2]
        else $error("command for another address accepted");
    addr_hold_a: assert property (!addr_we_i |=> addr_o == $past(addr_o)) // see [R3]
        else $error("address changed without a write");
    wake_any_a: assert property (st_q == ST_SLEEP && wake |=> st_q == ST_LISTEN && awake_o) // see [R4]
        else $error("start bit did not wake the block");
    quiet_line_a: assert property (!line_oe_b_o |-> st_q == ST_SEND) // see [R5]
        else $error("wire driven outside a reply");
    sleep_late_a: assert property (st_q == ST_LISTEN ##1 st_q == ST_SLEEP |-> $past(tmr_q) == '0) // see [R6]
        else $error("slept before the inactivity count ran out");
    term_bang_a: assert property (cmd_valid_o |-> $past(rx_vld_q && rx_chr_q == CH_BANG)) // see [R7]
        else $error("command reported without terminator");
    lf_after_cr_a: assert property (tx_load && tx_chr == CH_LF |-> last_chr_q == CH_CR) // see [R8]
        else $error("line feed not preceded by carriage return");
    bit_hold_a: assert property (tx_busy_q && tx_cnt_q != '0 |=> $stable(line_o)) // see [R9]
        else $error("wire changed inside a bit time");
    release_a: assert property (reply_end_s |-> line_oe_b_o && $past(last_chr_q) == CH_LF) // see [R10]
        else $error("wire not released after reply end");
endmodule : sdr_responder
